// [logic/ect_pkg.sv]
// package: register map, field layouts, enums and reset values of the compare timer
// Summary of operation
// - match flag a set when count equals constant a
// - no match a during constant a write cycle
// - both constants 8-bit read/write, reset all ones
// - irq enables bits 7,6,5 gate flags
// - clear field 00 none, 01 match a, 10 match b
// - clear code 11 clears on external clear rise
// - internal clocks divide by 4 to 128, code 000 stops
// - code 100 stops; 101/110/111 external edges
// - match flag b bit 7 on count equal b
// - flags cleared by writing 0 after reading 1
// - wrap flag bit 5 on ff to 00
// - flags bit 4 always reads one
// - match b drives output per upper action field
// - match a drives output per lower action field
// - actions independent; output low after reset
// - control bits reset to 0, read/write; ctl1 bits 7:5 and 1 read as one
// - counter 8-bit up, cpu read/write, resets zero
// - match raised in last state of equality
// - gate enable halts on clear, trigger resumes
// - trigger edge 00 off, 01 rise, 10 fall, 11 both
package ect_pkg;

  // ************************************************
  // register map
  // ************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_COUNT = 8'h00;
  localparam logic [7:0] OFF_CMP_A = 8'h04;
  localparam logic [7:0] OFF_CMP_B = 8'h08;
  localparam logic [7:0] OFF_CTL0 = 8'h0C;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_CTL1 = 8'h14;

  // ************************************************
  // reset values and field positions
  // ************************************************
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'hFF;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam int FLAG_B_BIT = 7;
  localparam int FLAG_A_BIT = 6;
  localparam int FLAG_W_BIT = 5;
  localparam int FLAG_RSVD_BIT = 4;
  localparam int PRE_W = 7;

  // ************************************************
  // modes
  // ************************************************
  typedef enum logic [1:0] {
    CLR_NONE = 2'b00,
    CLR_MATCH_A = 2'b01,
    CLR_MATCH_B = 2'b10,
    CLR_EXT = 2'b11
  } ect_clear_t;

  typedef enum logic [1:0] {
    ACT_KEEP = 2'b00,
    ACT_LOW = 2'b01,
    ACT_HIGH = 2'b10,
    ACT_TOGGLE = 2'b11
  } ect_action_t;

  typedef enum logic [1:0] {
    TRG_OFF = 2'b00,
    TRG_RISE = 2'b01,
    TRG_FALL = 2'b10,
    TRG_BOTH = 2'b11
  } ect_trig_t;

  localparam logic [2:0] CKS_EXT_RISE = 3'h5;
  localparam logic [2:0] CKS_EXT_FALL = 3'h6;
  localparam logic [2:0] CKS_EXT_BOTH = 3'h7;

  // ************************************************
  // register layouts
  // ************************************************
  typedef struct packed {
    logic match_b_irq_enable;
    logic match_a_irq_enable;
    logic wrap_irq_enable;
    ect_clear_t clear_select;
    logic [2:0] clock_select;
  } ect_ctl0_t;

  typedef struct packed {
    ect_trig_t trigger_edge;
    logic trigger_gate_enable;
    logic divisor_pick;
  } ect_ctl1_t;

  typedef struct packed {
    ect_action_t match_b_action;
    ect_action_t match_a_action;
  } ect_outsel_t;

  typedef struct packed {
    logic trigger_in;
    logic ext_clear_in;
    logic ext_count_in;
  } ect_pins_t;

endpackage

// [logic/ect_edge_sync.sv]
// two-stage synchroniser with rise and fall detection per pin
`timescale 1ns/1ns
module ect_edge_sync #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_edge
      assign rise[i] = sync_q[i] & ~prev_q[i];
      assign fall[i] = ~sync_q[i] & prev_q[i];
    end
  endgenerate
endmodule // ect_edge_sync

// [logic/ect_timer.sv]
// top: apb-mapped 8-bit compare timer with waveform output
`timescale 1ns/1ns
module ect_timer (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ect_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_COUNT_IN,
  input wire logic EXT_CLEAR_IN,
  input wire logic TRIGGER_IN,
  output logic WAVE_OUT,
  output logic IRQ_REQ
);

  // ************************************************
  // state
  // ************************************************
  logic [7:0] count_q;
  logic [7:0] cmp_a_q;
  logic [7:0] cmp_b_q;
  ect_pkg::ect_ctl0_t ctl0_q;
  ect_pkg::ect_ctl1_t ctl1_q;
  ect_pkg::ect_outsel_t outsel_q;
  logic [2:0] flags_q;
  logic [2:0] armed_q;
  logic [ect_pkg::PRE_W-1:0] pre_q;
  logic run_q;
  logic wave_q;
  logic ready_q;
  logic [31:0] rdata_q;
  logic slverr_q;
  logic irq_q;

  // ************************************************
  // bus decode
  // ************************************************
  logic access;
  logic commit;
  logic wr;
  logic rd;
  logic hit;
  logic wr_count;
  logic wr_cmp_a;
  logic wr_flags;
  logic [7:0] rd_mux;
  logic [7:0] flags_view;

  assign access = PSEL & PENABLE;
  assign commit = access & ready_q;
  assign wr = commit & PWRITE;
  assign rd = commit & ~PWRITE;
  assign wr_count = wr & (PADDR == ect_pkg::OFF_COUNT);
  assign wr_cmp_a = wr & (PADDR == ect_pkg::OFF_CMP_A);
  assign wr_flags = wr & (PADDR == ect_pkg::OFF_FLAGS);

  assign flags_view = {flags_q, 1'b1, outsel_q};

  always_comb begin
    hit = 1'b1;
    case (PADDR)
      ect_pkg::OFF_COUNT: rd_mux = count_q;
      ect_pkg::OFF_CMP_A: rd_mux = cmp_a_q;
      ect_pkg::OFF_CMP_B: rd_mux = cmp_b_q;
      ect_pkg::OFF_CTL0: rd_mux = ctl0_q;
      ect_pkg::OFF_FLAGS: rd_mux = flags_view;
      ect_pkg::OFF_CTL1: rd_mux = {3'b111, ctl1_q[3:1], 1'b1, ctl1_q[0]};
      default: begin
        rd_mux = 8'h00;
        hit = 1'b0;
      end
    endcase
  end

  // one wait state: answer is registered, so every access phase lasts two cycles
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ready_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else begin
      ready_q <= access & ~ready_q;
      if (access & ~ready_q) begin
        rdata_q <= {24'h00_0000, rd_mux};
        slverr_q <= ~hit;
      end
    end
  end

  // ************************************************
  // pin synchronisation
  // ************************************************
  ect_pkg::ect_pins_t pins;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  assign pins = '{trigger_in: TRIGGER_IN, ext_clear_in: EXT_CLEAR_IN,
                  ext_count_in: EXT_COUNT_IN};

  ect_edge_sync #(.W(3)) u_sync (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .pin_in(pins),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // ************************************************
  // count clock selection
  // ************************************************
  logic [2:0] shamt;
  logic [ect_pkg::PRE_W-1:0] pre_mask;
  logic int_tick;
  logic ext_tick;
  logic tick;
  logic trig_hit;

  // divide by 2^shamt; tick on the falling edge of that prescaler bit
  assign shamt = {ctl0_q.clock_select[1:0], 1'b0} + {2'b00, ctl1_q.divisor_pick};
  assign pre_mask = ect_pkg::PRE_W'((8'h01 << shamt) - 8'h01);
  assign int_tick = ~ctl0_q.clock_select[2] & (ctl0_q.clock_select[1:0] != 2'b00)
                    & (&(pre_q | ~pre_mask));

  always_comb begin
    case (ctl0_q.clock_select)
      ect_pkg::CKS_EXT_RISE: ext_tick = pin_rise[0];
      ect_pkg::CKS_EXT_FALL: ext_tick = pin_fall[0];
      ect_pkg::CKS_EXT_BOTH: ext_tick = pin_rise[0] | pin_fall[0];
      default: ext_tick = 1'b0;
    endcase
  end

  always_comb begin
    case (ctl1_q.trigger_edge)
      ect_pkg::TRG_RISE: trig_hit = pin_rise[2];
      ect_pkg::TRG_FALL: trig_hit = pin_fall[2];
      ect_pkg::TRG_BOTH: trig_hit = pin_rise[2] | pin_fall[2];
      default: trig_hit = 1'b0;
    endcase
  end

  assign tick = (int_tick | ext_tick) & run_q;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // ************************************************
  // compare, clear, overflow
  // ************************************************
  logic eq_a;
  logic eq_b;
  logic match_a;
  logic match_b;
  logic clr_match;
  logic clr_ext;
  logic clear_now;
  logic wrap;

  // a write landing in constant a must not produce a false match
  assign eq_a = (count_q == cmp_a_q) & ~wr_cmp_a;
  assign eq_b = (count_q == cmp_b_q);
  // match fires in the last cycle the values are equal, just before they part
  assign match_a = eq_a & tick;
  assign match_b = eq_b & tick;
  assign clr_match = ((ctl0_q.clear_select == ect_pkg::CLR_MATCH_A) & match_a)
                   | ((ctl0_q.clear_select == ect_pkg::CLR_MATCH_B) & match_b);
  assign clr_ext = (ctl0_q.clear_select == ect_pkg::CLR_EXT) & pin_rise[1];
  assign clear_now = clr_match | clr_ext;
  assign wrap = tick & (count_q == ect_pkg::COUNT_MAX) & ~clear_now & ~wr_count;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      count_q <= ect_pkg::COUNT_RST;
    end else if (wr_count) begin
      count_q <= PWDATA[7:0];
    end else if (clear_now) begin
      count_q <= ect_pkg::COUNT_RST;
    end else if (tick) begin
      count_q <= count_q + 8'h01;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      run_q <= 1'b1;
    end else if (!ctl1_q.trigger_gate_enable) begin
      run_q <= 1'b1;
    end else if (trig_hit) begin
      run_q <= 1'b1;
    end else if (clear_now) begin
      run_q <= 1'b0;
    end
  end

  // ************************************************
  // software registers
  // ************************************************
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      cmp_a_q <= ect_pkg::CMP_RST;
      cmp_b_q <= ect_pkg::CMP_RST;
    end else begin
      if (wr_cmp_a) begin
        cmp_a_q <= PWDATA[7:0];
      end
      if (wr & (PADDR == ect_pkg::OFF_CMP_B)) begin
        cmp_b_q <= PWDATA[7:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ctl0_q <= ect_pkg::CTL_RST;
      ctl1_q <= '0;
      outsel_q <= '0;
    end else begin
      if (wr & (PADDR == ect_pkg::OFF_CTL0)) begin
        ctl0_q <= PWDATA[7:0];
      end
      if (wr & (PADDR == ect_pkg::OFF_CTL1)) begin
        ctl1_q <= {PWDATA[4:2], PWDATA[0]};
      end
      if (wr_flags) begin
        outsel_q <= PWDATA[3:0];
      end
    end
  end

  // ************************************************
  // flags: a zero write clears only a bit last read as one
  // ************************************************
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  assign flag_set = {match_b, match_a, wrap};
  assign flag_clr = {3{wr_flags}} & armed_q
                  & ~PWDATA[ect_pkg::FLAG_B_BIT:ect_pkg::FLAG_W_BIT];

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      flags_q <= 3'h0;
      armed_q <= 3'h0;
    end else begin
      flags_q <= flag_set | (flags_q & ~flag_clr);
      if (rd & (PADDR == ect_pkg::OFF_FLAGS)) begin
        // arm from the word handed back, not from flags set after it was latched
        armed_q <= rdata_q[ect_pkg::FLAG_B_BIT:ect_pkg::FLAG_W_BIT];
      end else if (wr_flags) begin
        armed_q <= 3'h0;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags_q & {ctl0_q.match_b_irq_enable, ctl0_q.match_a_irq_enable,
                            ctl0_q.wrap_irq_enable});
    end
  end

  // ************************************************
  // waveform output
  // ************************************************
  function automatic logic apply_act(input ect_pkg::ect_action_t act, input logic lvl);
    case (act)
      ect_pkg::ACT_LOW: apply_act = 1'b0;
      ect_pkg::ACT_HIGH: apply_act = 1'b1;
      ect_pkg::ACT_TOGGLE: apply_act = ~lvl;
      default: apply_act = lvl;
    endcase
  endfunction

  logic wave_a;
  logic wave_d;

  assign wave_a = match_a ? apply_act(outsel_q.match_a_action, wave_q) : wave_q;
  // both matches in one cycle: match b acts on the result of match a
  assign wave_d = match_b ? apply_act(outsel_q.match_b_action, wave_a) : wave_a;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      wave_q <= 1'b0;
    end else begin
      wave_q <= wave_d;
    end
  end

  assign PRDATA = rdata_q;
  assign PREADY = ready_q;
  assign PSLVERR = slverr_q;
  assign WAVE_OUT = wave_q;
  assign IRQ_REQ = irq_q;

  // ************************************************
  // checks
  // ************************************************
  chk_match_a_flag: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (eq_a && tick) |=> flags_q[1]) else $error("match a did not set its flag");
  chk_cmp_write_mask: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (wr_cmp_a && !flags_q[1]) |=> !flags_q[1]) else $error("match a raised during constant write");
  chk_cmp_reset: assert property (@(posedge CLK_SYS)
    SYS_RST |=> (cmp_a_q == 8'hFF) && (cmp_b_q == 8'hFF)) else $error("constants not ff");
  chk_irq_gate: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (flags_q[2] && ctl0_q.match_b_irq_enable) |=> IRQ_REQ) else $error("irq b missing");
  chk_clear_match: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (ctl0_q.clear_select == ect_pkg::CLR_MATCH_B && match_b && !wr_count)
    |=> count_q == 8'h00) else $error("match b clear failed");
  chk_ext_clear: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (clr_ext && !wr_count) |=> count_q == 8'h00) else $error("external clear failed");
  chk_stop_codes: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (ctl0_q.clock_select[1:0] == 2'b00 && !wr_count && !clr_ext) |=> $stable(count_q))
    else $error("counted while stopped");
  chk_wrap_flag: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    ($past(count_q) == 8'hFF && count_q == 8'h00 && !$past(clear_now) && !$past(wr_count))
    |-> flags_q[0]) else $error("wrap flag not set");
  chk_flag_clear: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    $fell(flags_q[0]) |-> $past(wr_flags && armed_q[0])) else $error("flag cleared unread");
  chk_rsvd_read: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (rd && PADDR == ect_pkg::OFF_FLAGS) |-> PRDATA[4]) else $error("reserved bit not one");
  chk_wave_a_high: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (match_a && !match_b && outsel_q.match_a_action == ect_pkg::ACT_HIGH) |=> WAVE_OUT)
    else $error("match a high action missing");
  chk_cpu_priority: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    wr_count |=> count_q == $past(PWDATA[7:0])) else $error("counter write lost");
  chk_gate_halt: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (ctl1_q.trigger_gate_enable && clear_now && !trig_hit) |=> !run_q)
    else $error("gate did not halt on clear");

endmodule // ect_timer

// [test/ect_pin_model.sv]
// partner model: drives the external count, clear and trigger pins
`timescale 1ns/1ns
module ect_pin_model (
  input wire logic clk,
  output logic count_pin,
  output logic clear_pin,
  output logic trig_pin
);
  // ****************
  // pin drivers
  // ****************
  initial begin
    count_pin = 1'b0;
    clear_pin = 1'b0;
    trig_pin = 1'b0;
  end
  // levels hold at least eight cycles: narrower ones may vanish in the synchroniser
  task automatic toggle(input int sel);
    repeat (4) @(posedge clk);
    case (sel)
      0: count_pin <= ~count_pin;
      1: clear_pin <= ~clear_pin;
      default: trig_pin <= ~trig_pin;
    endcase
    repeat (4) @(posedge clk);
  endtask
endmodule // ect_pin_model

// [test/eight_bit_compare_timer_bench.sv]
// bench: register, pin and waveform scenarios of the compare timer
`timescale 1ns/1ns
module eight_bit_compare_timer_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ect_pkg::ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cpin;
  logic rpin;
  logic tpin;
  logic wave;
  logic irq;
  logic [31:0] rdv;
  logic erv;
  int err_count = 0;
  int checked = 0;

  always #4 clk = ~clk;

  ect_timer u_dut (.CLK_SYS(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EXT_COUNT_IN(cpin), .EXT_CLEAR_IN(rpin), .TRIGGER_IN(tpin),
    .WAVE_OUT(wave), .IRQ_REQ(irq));
  ect_pin_model u_pins (.clk(clk), .count_pin(cpin), .clear_pin(rpin), .trig_pin(tpin));

  // ****************
  // shared tasks
  // ****************
  task automatic conclude();
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // entered just after a rising edge; one idle cycle follows each transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) err_count++;
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    check(what, rdv, {24'h0, exp});
  endtask

  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      u_pins.toggle(sel);
      u_pins.toggle(sel);
    end
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    check("wave", wave, 1'b0);
    rd("count", ect_pkg::OFF_COUNT, ect_pkg::COUNT_RST);
    rd("cmp a", ect_pkg::OFF_CMP_A, ect_pkg::CMP_RST);
    rd("cmp b", ect_pkg::OFF_CMP_B, ect_pkg::CMP_RST);
    rd("ctl0", ect_pkg::OFF_CTL0, ect_pkg::CTL_RST);
    rd("flags", ect_pkg::OFF_FLAGS, 8'h10);
    rd("ctl1", ect_pkg::OFF_CTL1, 8'hE2);
    apb(1'b0, 8'h18, 8'h00);
    check("unmapped err", erv, 1'b1);
    check("unmapped data", rdv, 32'h0);
    wr(ect_pkg::OFF_CMP_A, 8'h5A);
    rd("cmp a rw", ect_pkg::OFF_CMP_A, 8'h5A);
    wr(ect_pkg::OFF_CTL0, 8'hE4);
    rd("ctl0 rw", ect_pkg::OFF_CTL0, 8'hE4);
    check("irq idle", irq, 1'b0);
    wr(ect_pkg::OFF_COUNT, 8'h33);
    rd("count rw", ect_pkg::OFF_COUNT, 8'h33);
    wr(ect_pkg::OFF_CTL0, 8'h00);
  endtask

  task automatic t_ext_clk();
    for (int c = 4; c < 8; c++) begin
      wr(ect_pkg::OFF_COUNT, 8'h00);
      wr(ect_pkg::OFF_CTL0, 8'(c));
      pulse(0, 2);
      wr(ect_pkg::OFF_CTL0, 8'h00);
      rd("ext count", ect_pkg::OFF_COUNT, (c == 7) ? 8'h04 : (c == 4) ? 8'h00 : 8'h02);
    end
  endtask

  task automatic t_internal();
    int n;
    for (int k = 0; k < 6; k++) begin
      n = 4 << k;
      wr(ect_pkg::OFF_CTL1, 8'(k % 2));
      wr(ect_pkg::OFF_COUNT, 8'h00);
      wr(ect_pkg::OFF_CTL0, 8'(k / 2 + 1));
      repeat (8 * n) @(posedge clk);
      wr(ect_pkg::OFF_CTL0, 8'h00);
      apb(1'b0, ect_pkg::OFF_COUNT, 8'h00);
      // prescaler phase is free running, so allow a couple of ticks of slack
      check("div ticks", rdv >= 8 && rdv <= 10, 1'b1);
    end
    wr(ect_pkg::OFF_CTL1, 8'h00);
  endtask

  task automatic t_match_a();
    wr(ect_pkg::OFF_CMP_A, 8'h02);
    wr(ect_pkg::OFF_CMP_B, 8'h80);
    wr(ect_pkg::OFF_FLAGS, 8'h02);
    wr(ect_pkg::OFF_COUNT, 8'h00);
    wr(ect_pkg::OFF_CTL0, 8'h4D);
    pulse(0, 3);
    rd("count clr a", ect_pkg::OFF_COUNT, 8'h00);
    check("wave high", wave, 1'b1);
    check("irq a", irq, 1'b1);
    wr(ect_pkg::OFF_FLAGS, 8'h02);
    rd("flag a kept", ect_pkg::OFF_FLAGS, 8'h52);
    wr(ect_pkg::OFF_FLAGS, 8'h02);
    rd("flag a clr", ect_pkg::OFF_FLAGS, 8'h12);
    check("irq a off", irq, 1'b0);
  endtask

  task automatic t_match_b();
    wr(ect_pkg::OFF_FLAGS, 8'h0C);
    wr(ect_pkg::OFF_CMP_B, 8'h01);
    wr(ect_pkg::OFF_COUNT, 8'h00);
    wr(ect_pkg::OFF_CTL0, 8'h95);
    pulse(0, 2);
    rd("count clr b", ect_pkg::OFF_COUNT, 8'h00);
    check("wave toggle", wave, 1'b0);
    check("irq b", irq, 1'b1);
    rd("flag b", ect_pkg::OFF_FLAGS, 8'h9C);
    wr(ect_pkg::OFF_FLAGS, 8'h0C);
    pulse(0, 2);
    check("wave toggle back", wave, 1'b1);
  endtask

  task automatic t_wrap();
    wr(ect_pkg::OFF_FLAGS, 8'h00);
    wr(ect_pkg::OFF_COUNT, 8'hFF);
    wr(ect_pkg::OFF_CTL0, 8'h25);
    pulse(0, 1);
    rd("count wrap", ect_pkg::OFF_COUNT, 8'h00);
    rd("wrap flag", ect_pkg::OFF_FLAGS, 8'hB0);
    check("irq wrap", irq, 1'b1);
    wr(ect_pkg::OFF_FLAGS, 8'h00);
    rd("wrap clr", ect_pkg::OFF_FLAGS, 8'h10);
  endtask

  task automatic t_ext_clear();
    wr(ect_pkg::OFF_CTL0, 8'h00);
    wr(ect_pkg::OFF_COUNT, 8'h20);
    pulse(1, 1);
    rd("no ext clr", ect_pkg::OFF_COUNT, 8'h20);
    wr(ect_pkg::OFF_CTL0, 8'h18);
    pulse(1, 1);
    rd("ext clr", ect_pkg::OFF_COUNT, 8'h00);
  endtask

  task automatic t_trigger();
    wr(ect_pkg::OFF_FLAGS, 8'h01);
    wr(ect_pkg::OFF_CTL1, 8'h0C);
    wr(ect_pkg::OFF_COUNT, 8'h00);
    wr(ect_pkg::OFF_CTL0, 8'h0D);
    pulse(0, 4);
    rd("halted", ect_pkg::OFF_COUNT, 8'h00);
    check("wave low", wave, 1'b0);
    u_pins.toggle(2);
    pulse(0, 1);
    rd("resumed", ect_pkg::OFF_COUNT, 8'h01);
    pulse(0, 2);
    u_pins.toggle(2);
    pulse(0, 1);
    rd("fall ignored", ect_pkg::OFF_COUNT, 8'h00);
    wr(ect_pkg::OFF_CTL1, 8'h14);
    u_pins.toggle(2);
    pulse(0, 1);
    rd("rise ignored", ect_pkg::OFF_COUNT, 8'h00);
    u_pins.toggle(2);
    pulse(0, 1);
    rd("fall resumed", ect_pkg::OFF_COUNT, 8'h01);
    wr(ect_pkg::OFF_CTL1, 8'h1C);
    pulse(0, 2);
    rd("both halted", ect_pkg::OFF_COUNT, 8'h00);
    u_pins.toggle(2);
    pulse(0, 1);
    rd("both resumed", ect_pkg::OFF_COUNT, 8'h01);
    wr(ect_pkg::OFF_CTL1, 8'h00);
    wr(ect_pkg::OFF_CTL0, 8'h00);
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_ext_clk();
    t_internal();
    t_match_a();
    t_match_b();
    t_wrap();
    t_ext_clear();
    t_trigger();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end
endmodule // eight_bit_compare_timer_bench
